//--- wbl_pkg.sv
// shared constants for the white-balance and pattern scroll block
`default_nettype none
package wbl_pkg;
  localparam int LUT_W = 8;
  localparam int LUT_D = 256;
  localparam int NSLOT = 16;
  localparam int PAT_W = 5;
  // register offsets on the parallel req/ack control bus
  localparam logic [7:0] ADR_CTRL  = 8'h00;
  localparam logic [7:0] ADR_STAT  = 8'h01;
  localparam logic [7:0] ADR_PAGE  = 8'h02;
  localparam logic [7:0] ADR_LIDX  = 8'h03;
  localparam logic [7:0] ADR_LDAT  = 8'h04;
  localparam logic [7:0] ADR_PIADR = 8'h05;
  localparam logic [7:0] ADR_PIDAT = 8'h06;
  // control bit positions
  localparam int CB_WB_EN   = 0;
  localparam int CB_RELOAD  = 1;
  localparam int CB_DITHER2 = 2;
  localparam int CB_IN6     = 3;
  localparam int CB_SCROLL  = 4;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // table pages
  localparam logic [7:0] PAGE_NONE  = 8'h00;
  localparam logic [7:0] PAGE_RED   = 8'h01;
  localparam logic [7:0] PAGE_GREEN = 8'h02;
  localparam logic [7:0] PAGE_BLUE  = 8'h03;
  // indirect pattern map
  localparam logic [7:0] IND_SLOT_CNT = 8'h10;
  localparam logic [7:0] IND_FIXED    = 8'h11;
  localparam logic [4:0] SLOT_CNT_RST = 5'h10;
  localparam logic [4:0] PAT_RST      = 5'h01;
  localparam logic [7:0] LAST_ENTRY   = 8'hff;
  localparam logic [7:0] LSB_MASK     = 8'hfc;
endpackage : wbl_pkg
`default_nettype wire

//--- wbl_if.sv
// register access carrier between host and device
`timescale 1ns/1ps
`default_nettype none
interface wbl_if;
  logic       req;
  logic       we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       ack;
  logic [7:0] rdata;
  modport dev  (input req, we, addr, wdata, output ack, rdata);
  modport host (output req, we, addr, wdata, input ack, rdata);
endinterface : wbl_if
`default_nettype wire

//--- wbl_lut.sv
// one colour table: host write, host read, registered pixel read
`timescale 1ns/1ps
`default_nettype none
module wbl_lut #(
  parameter int W = 8,
  parameter int D = 256,
  parameter int A = $clog2(D)
) (
  input  wire logic         clk_sys,
  input  wire logic         we,
  input  wire logic [A-1:0] haddr,
  input  wire logic [W-1:0] wdata,
  output logic      [W-1:0] hdata,
  input  wire logic [A-1:0] paddr,
  output logic      [W-1:0] pdata
);
  logic [W-1:0] mem [D];
  logic [W-1:0] pdata_reg;

  assign hdata = mem[haddr];
  assign pdata = pdata_reg;

  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[haddr] <= wdata;
    end
    pdata_reg <= mem[paddr];
  end
endmodule : wbl_lut
`default_nettype wire

//--- wbl_dev.sv
// device end: pattern scroll, indirect window and white-balance path
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - auto-scroll steps through enabled pattern list
// - sixteen slots, any pattern, repeats allowed
// - extra settings via indirect address and data
// - three tables, 256 entries of 8 bits
// - enabled: component replaced by own-table entry
// - every table entry writable and readable
// - host loads tables, device is slave
// - host fills all tables, zero unused bits
// - 24-bit mode sends 8-bit remapped values
// - 6-bit input gives 64 values, 8-bit result
// - 6-bit/8-bit mode dithers output to 6 bits
// - first load order red, green, blue
// - page register selects accessed table
// - host loads all tables before enabling
// - no table writes after init unless reload
// - reload bit permits rewriting tables
// - reload while enabled, video uninterrupted
// - partial updates accepted during reload
// - remap also serves 666 and 565 data
// - second dither drives only six high bits
module wbl_dev #(
  parameter int NS = wbl_pkg::NSLOT
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rstn,
  wbl_if.dev                            bus,
  input  wire logic                     pix_valid,
  input  wire logic [wbl_pkg::LUT_W-1:0] pix_r,
  input  wire logic [wbl_pkg::LUT_W-1:0] pix_g,
  input  wire logic [wbl_pkg::LUT_W-1:0] pix_b,
  input  wire logic                     frame_start,
  output logic                          out_valid,
  output logic      [wbl_pkg::LUT_W-1:0] out_r,
  output logic      [wbl_pkg::LUT_W-1:0] out_g,
  output logic      [wbl_pkg::LUT_W-1:0] out_b,
  output logic      [wbl_pkg::PAT_W-1:0] pat_sel
);
  import wbl_pkg::*;

  logic [7:0]       ctrl_reg;
  logic [7:0]       page_reg;
  logic [7:0]       lidx_reg;
  logic [7:0]       piadr_reg;
  logic [PAT_W-1:0] slot_reg [NS];
  logic [4:0]       slot_cnt_reg;
  logic [PAT_W-1:0] fixed_reg;
  logic [3:0]       scroll_reg;
  logic [PAT_W-1:0] pat_reg;
  logic [2:0]       loaded_reg;
  logic             init_reg;
  logic             ack_reg;
  logic [7:0]       rdata_reg;
  logic             v1_reg;
  logic [23:0]      raw1_reg;
  logic             v2_reg;
  logic [23:0]      out_reg;
  logic             fpar_reg;
  logic             ppar_reg;

  // bus decode
  wire take    = bus.req & ~ack_reg;
  wire wr      = take & bus.we;
  wire a_ctrl  = bus.addr == ADR_CTRL;
  wire a_page  = bus.addr == ADR_PAGE;
  wire a_lidx  = bus.addr == ADR_LIDX;
  wire a_ldat  = bus.addr == ADR_LDAT;
  wire a_piadr = bus.addr == ADR_PIADR;
  wire a_pidat = bus.addr == ADR_PIDAT;
  wire a_stat  = bus.addr == ADR_STAT;
  wire wr_ok   = ~init_reg | ctrl_reg[CB_RELOAD];
  wire [2:0] pg_hit = {page_reg == PAGE_BLUE, page_reg == PAGE_GREEN,
                       page_reg == PAGE_RED};
  wire [2:0] lut_we = {3{wr & a_ldat & wr_ok}} & pg_hit;
  wire [2:0] loaded_next = loaded_reg | (lut_we & {3{lidx_reg == LAST_ENTRY}});
  wire pi_slot = piadr_reg < 8'(NS);
  wire [3:0] pi_idx = piadr_reg[3:0];

  // colour pipeline signals
  wire in6 = ctrl_reg[CB_IN6];
  wire [7:0] idx_r = in6 ? {pix_r[7:2], 2'b00} : pix_r;
  wire [7:0] idx_g = in6 ? {pix_g[7:2], 2'b00} : pix_g;
  wire [7:0] idx_b = in6 ? {pix_b[7:2], 2'b00} : pix_b;
  logic [7:0] hd [3];
  logic [7:0] pd [3];
  wire [7:0] sel_hd = pg_hit[0] ? hd[0] : pg_hit[1] ? hd[1] :
                      pg_hit[2] ? hd[2] : 8'h00;
  wire [23:0] lut_rgb = {pd[0], pd[1], pd[2]};
  wire [23:0] wb_rgb  = ctrl_reg[CB_WB_EN] ? lut_rgb : raw1_reg;
  wire [1:0] thr = {fpar_reg, ppar_reg};

  function automatic logic [7:0] dith(input logic [7:0] c,
                                      input logic [1:0] t);
    logic [5:0] hi;
    hi = c[7:2];
    if (c[1:0] > t && hi != 6'h3f) begin
      hi = hi + 6'h01;
    end
    return {hi, 2'b00};
  endfunction : dith

  wire [23:0] dith_rgb = {dith(wb_rgb[23:16], thr),
                          dith(wb_rgb[15:8], thr),
                          dith(wb_rgb[7:0], thr)};
  // 24-bit, 666 and 565 all pass the same remap; narrow codes sit high
  wire [23:0] final_rgb = ctrl_reg[CB_DITHER2] ? dith_rgb : wb_rgb;

  logic [7:0] rd_val;
  always_comb begin
    rd_val = 8'h00;
    if (a_ctrl) begin
      rd_val = ctrl_reg;
    end else if (a_stat) begin
      rd_val = {4'h0, loaded_reg, init_reg};
    end else if (a_page) begin
      rd_val = page_reg;
    end else if (a_lidx) begin
      rd_val = lidx_reg;
    end else if (a_ldat) begin
      rd_val = sel_hd;
    end else if (a_piadr) begin
      rd_val = piadr_reg;
    end else if (a_pidat) begin
      if (pi_slot) begin
        rd_val = {3'h0, slot_reg[pi_idx]};
      end else if (piadr_reg == IND_SLOT_CNT) begin
        rd_val = {3'h0, slot_cnt_reg};
      end else if (piadr_reg == IND_FIXED) begin
        rd_val = {3'h0, fixed_reg};
      end
    end
  end

  // three tables, host port separate from pixel port
  for (genvar i = 0; i < 3; i++) begin : g_lut
    wire [7:0] pa = (i == 0) ? idx_r : (i == 1) ? idx_g : idx_b;
    wbl_lut #(.W(LUT_W), .D(LUT_D)) u_lut (
      .clk_sys (clk_sys),
      .we      (lut_we[i]),
      .haddr   (lidx_reg),
      .wdata   (bus.wdata),
      .hdata   (hd[i]),
      .paddr   (pa),
      .pdata   (pd[i])
    );
  end

  // register access, one-cycle acknowledge
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ack_reg    <= 1'b0;
      rdata_reg  <= 8'h00;
      ctrl_reg   <= CTRL_RST;
      page_reg   <= PAGE_NONE;
      lidx_reg   <= 8'h00;
      piadr_reg  <= 8'h00;
      loaded_reg <= 3'h0;
      init_reg   <= 1'b0;
    end else begin
      ack_reg <= take;
      if (take) begin
        rdata_reg <= bus.we ? 8'h00 : rd_val;
      end
      if (wr && a_ctrl) begin
        ctrl_reg <= bus.wdata;
      end
      if (wr && a_page) begin
        page_reg <= bus.wdata;
      end
      if (wr && a_piadr) begin
        piadr_reg <= bus.wdata;
      end
      if (wr && a_lidx) begin
        lidx_reg <= bus.wdata;
      end else if (take && a_ldat) begin
        lidx_reg <= lidx_reg + 8'h01;
      end
      if (!init_reg) begin
        loaded_reg <= loaded_next;
        init_reg   <= &loaded_next;
      end
    end
  end

  // indirect pattern settings and auto-scroll
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      for (int k = 0; k < NS; k++) begin
        slot_reg[k] <= PAT_RST;
      end
      slot_cnt_reg <= SLOT_CNT_RST;
      fixed_reg    <= PAT_RST;
      scroll_reg   <= 4'h0;
      pat_reg      <= PAT_RST;
    end else begin
      if (wr && a_pidat && pi_slot) begin
        slot_reg[pi_idx] <= bus.wdata[PAT_W-1:0];
      end
      if (wr && a_pidat && piadr_reg == IND_SLOT_CNT) begin
        slot_cnt_reg <= bus.wdata[4:0];
      end
      if (wr && a_pidat && piadr_reg == IND_FIXED) begin
        fixed_reg <= bus.wdata[PAT_W-1:0];
      end
      if (!ctrl_reg[CB_SCROLL]) begin
        scroll_reg <= 4'h0;
        pat_reg    <= fixed_reg;
      end else if (frame_start) begin
        if ({1'b0, scroll_reg} + 5'h01 >= slot_cnt_reg) begin
          scroll_reg <= 4'h0;
          pat_reg    <= slot_reg[0];
        end else begin
          scroll_reg <= scroll_reg + 4'h1;
          pat_reg    <= slot_reg[scroll_reg + 4'h1];
        end
      end
    end
  end

  // pixel pipeline, two cycles, runs during table updates
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      v1_reg   <= 1'b0;
      raw1_reg <= 24'h00_0000;
      v2_reg   <= 1'b0;
      out_reg  <= 24'h00_0000;
      fpar_reg <= 1'b0;
      ppar_reg <= 1'b0;
    end else begin
      v1_reg   <= pix_valid;
      raw1_reg <= {idx_r, idx_g, idx_b};
      v2_reg   <= v1_reg;
      out_reg  <= final_rgb;
      if (frame_start) begin
        fpar_reg <= ~fpar_reg;
        ppar_reg <= 1'b0;
      end else if (v1_reg) begin
        ppar_reg <= ~ppar_reg;
      end
    end
  end

  assign bus.ack   = ack_reg;
  assign bus.rdata = rdata_reg;
  assign out_valid = v2_reg;
  assign out_r     = out_reg[23:16];
  assign out_g     = out_reg[15:8];
  assign out_b     = out_reg[7:0];
  assign pat_sel   = pat_reg;
endmodule : wbl_dev
`default_nettype wire

//--- wbl_host.sv
// host end: table loader and plain register command port
`timescale 1ns/1ps
`default_nettype none
module wbl_host (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  wbl_if.host             bus,
  input  wire logic       init_start,
  input  wire logic [7:0] ld_ctrl,
  input  wire logic       ld_zero_lsb,
  input  wire logic [7:0] ld_data,
  output logic            ld_req,
  output logic      [1:0] ld_table,
  output logic      [7:0] ld_index,
  output logic            init_done,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_we,
  input  wire logic [7:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  output logic            rsp_valid,
  output logic      [7:0] rsp_data
);
  import wbl_pkg::*;

  typedef enum logic [5:0] {
    S_IDLE = 6'b00_0001,
    S_PAGE = 6'b00_0010,
    S_LIDX = 6'b00_0100,
    S_DATA = 6'b00_1000,
    S_EN   = 6'b01_0000,
    S_CMD  = 6'b10_0000
  } wbl_state_e;

  wbl_state_e state_reg;
  logic [1:0] tbl_reg;
  logic [8:0] idx_reg;
  logic       req_reg;
  logic       we_reg;
  logic [7:0] addr_reg;
  logic [7:0] wdata_reg;
  logic       done_reg;
  logic       rsp_reg;
  logic [7:0] rspd_reg;

  wire idle = state_reg == S_IDLE;
  wire [7:0] ld_word = ld_data & (ld_zero_lsb ? LSB_MASK : 8'hff);
  wire fetch = bus.ack & ~idx_reg[8] &
               (state_reg == S_LIDX || state_reg == S_DATA);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_reg <= S_IDLE;
      tbl_reg   <= 2'h0;
      idx_reg   <= 9'h000;
      req_reg   <= 1'b0;
      we_reg    <= 1'b0;
      addr_reg  <= 8'h00;
      wdata_reg <= 8'h00;
      done_reg  <= 1'b0;
      rsp_reg   <= 1'b0;
      rspd_reg  <= 8'h00;
    end else begin
      rsp_reg <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (init_start) begin
            req_reg   <= 1'b1;
            we_reg    <= 1'b1;
            addr_reg  <= ADR_PAGE;
            wdata_reg <= PAGE_RED;
            tbl_reg   <= 2'h0;
            done_reg  <= 1'b0;
            state_reg <= S_PAGE;
          end else if (cmd_valid) begin
            req_reg   <= 1'b1;
            we_reg    <= cmd_we;
            addr_reg  <= cmd_addr;
            wdata_reg <= cmd_wdata;
            state_reg <= S_CMD;
          end
        end
        S_PAGE: begin
          if (bus.ack) begin
            addr_reg  <= ADR_LIDX;
            wdata_reg <= 8'h00;
            idx_reg   <= 9'h000;
            state_reg <= S_LIDX;
          end
        end
        S_LIDX, S_DATA: begin
          if (bus.ack && idx_reg[8]) begin
            if (tbl_reg == 2'h2) begin
              addr_reg  <= ADR_CTRL;
              wdata_reg <= ld_ctrl;
              state_reg <= S_EN;
            end else begin
              tbl_reg   <= tbl_reg + 2'h1;
              addr_reg  <= ADR_PAGE;
              wdata_reg <= PAGE_RED + {6'h00, tbl_reg} + 8'h01;
              state_reg <= S_PAGE;
            end
          end else if (fetch) begin
            addr_reg  <= ADR_LDAT;
            wdata_reg <= ld_word;
            idx_reg   <= idx_reg + 9'h001;
            state_reg <= S_DATA;
          end
        end
        S_EN: begin
          if (bus.ack) begin
            req_reg   <= 1'b0;
            done_reg  <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        S_CMD: begin
          if (bus.ack) begin
            req_reg   <= 1'b0;
            rsp_reg   <= 1'b1;
            rspd_reg  <= bus.rdata;
            state_reg <= S_IDLE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  assign bus.req   = req_reg;
  assign bus.we    = we_reg;
  assign bus.addr  = addr_reg;
  assign bus.wdata = wdata_reg;
  assign ld_req    = fetch;
  assign ld_table  = tbl_reg;
  assign ld_index  = idx_reg[7:0];
  assign init_done = done_reg;
  assign cmd_ready = idle & ~init_start;
  assign rsp_valid = rsp_reg;
  assign rsp_data  = rspd_reg;
endmodule : wbl_host
`default_nettype wire

//--- wbl_properties.sv
// handshake and readback checks on the register carrier
`timescale 1ns/1ps
`default_nettype none
module wbl_properties
  import wbl_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic       req,
  input wire logic       we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       ack,
  input wire logic [7:0] rdata
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic [7:0] page_reg;
  logic [7:0] ctrl_reg;
  wire        rd_done = ack && !we;
  wire        no_page = page_reg == PAGE_NONE || page_reg > PAGE_BLUE;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      page_reg <= PAGE_NONE;
      ctrl_reg <= CTRL_RST;
    end else if (ack && we && addr == ADR_PAGE) begin
      page_reg <= wdata;
    end else if (ack && we && addr == ADR_CTRL) begin
      ctrl_reg <= wdata;
    end
  end
  sequence s_take;
    req && !ack;
  endsequence
  sequence s_answer;
    ack ##1 !ack;
  endsequence
  a_ack_in_one: assert property (s_take |=> s_answer)
    else $error("ack not one cycle after request");
  a_ack_cause: assert property (ack |-> $past(req) && !$past(ack))
    else $error("ack without request");
  a_req_held: assert property (s_take |=> req)
    else $error("request dropped before ack");
  a_fields_held: assert property (s_take |=> $stable(addr) && $stable(we)
    && $stable(wdata)) else $error("fields changed before ack");
  a_wr_zero: assert property (ack && we |-> rdata == 8'h00)
    else $error("read data not zero on write");
  a_unmapped_zero: assert property (rd_done && addr > ADR_PIDAT
    |-> rdata == 8'h00) else $error("unmapped read not zero");
  a_nopage_zero: assert property (rd_done && addr == ADR_LDAT && no_page
    |-> rdata == 8'h00) else $error("table read without page");
  a_ctrl_back: assert property (rd_done && addr == ADR_CTRL
    |-> rdata[4:0] == ctrl_reg[4:0]) else $error("control readback");
  a_page_back: assert property (rd_done && addr == ADR_PAGE
    |-> rdata[1:0] == page_reg[1:0]) else $error("page readback");
endmodule : wbl_properties
`default_nettype wire

//--- pattern_scroll_white_balance_lut_tb.sv
// bench joining host and device ends over the carrier
`timescale 1ns/1ps
`default_nettype none
module pattern_scroll_white_balance_lut_tb;
  import wbl_pkg::*;
  typedef struct packed {
    logic        c;
    logic        v;
    logic [23:0] p;
  } wbl_exp_s;
  logic       clk_sys, rstn, init_start, ld_zero_lsb, ld_req, init_done;
  logic       cmd_valid, cmd_ready, cmd_we, rsp_valid, pix_valid;
  logic       frame_start, out_valid, msk, pix_on, pix_fix, vb;
  logic [7:0] ld_ctrl, ld_data, ld_index, cmd_addr, cmd_wdata, rsp_data;
  logic [7:0] pix_r, pix_g, pix_b, out_r, out_g, out_b, ctrl_m, r8, g8, b8;
  logic [1:0] ld_table;
  logic [4:0] pat_sel;
  logic [7:0] src [0:2][0:255];
  wbl_exp_s   pq [$];
  wbl_exp_s   pe;
  int         n_fail, n_tests, seed, ld_cnt, k;
  wbl_if bus ();
  wbl_dev wbl_dev_inst (.clk_sys(clk_sys), .rstn(rstn), .bus(bus),
    .pix_valid(pix_valid), .pix_r(pix_r), .pix_g(pix_g), .pix_b(pix_b),
    .frame_start(frame_start), .out_valid(out_valid), .out_r(out_r),
    .out_g(out_g), .out_b(out_b), .pat_sel(pat_sel));
  wbl_host wbl_host_inst (.clk_sys(clk_sys), .rstn(rstn), .bus(bus),
    .init_start(init_start), .ld_ctrl(ld_ctrl), .ld_zero_lsb(ld_zero_lsb),
    .ld_data(ld_data), .ld_req(ld_req), .ld_table(ld_table),
    .ld_index(ld_index), .init_done(init_done), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_we(cmd_we), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  wbl_properties wbl_properties_inst (.clk_sys(clk_sys), .rstn(rstn),
    .req(bus.req), .we(bus.we), .addr(bus.addr), .wdata(bus.wdata),
    .ack(bus.ack), .rdata(bus.rdata));
  assign ld_data = (ld_table < 2'd3) ? src[ld_table][ld_index] : 8'h00;
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  function automatic logic [7:0] exp_px(input logic [7:0] c, input int t);
    logic [7:0] v;
    logic [7:0] w;
    v = ctrl_m[CB_IN6] ? {c[7:2], 2'b00} : c;
    w = ctrl_m[CB_WB_EN] ? (src[t][v] & (msk ? LSB_MASK : 8'hff)) : v;
    return ctrl_m[CB_DITHER2] ? (w & LSB_MASK) : w;
  endfunction : exp_px
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk1
  task report_and_stop;
    if (n_fail == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task automatic cmd(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    int j;
    if (w && a == ADR_CTRL) ctrl_m = d;
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_we <= w;
    cmd_addr <= a;
    cmd_wdata <= d;
    j = 0;
    do @(posedge clk_sys); while (cmd_ready !== 1'b1 && ++j < 99);
    cmd_valid <= 1'b0;
    do @(posedge clk_sys); while (rsp_valid !== 1'b1 && ++j < 199);
    r = rsp_data;
    chk1(rsp_valid, 1'b1);
  endtask : cmd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    cmd(1'b1, a, d, r);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    cmd(1'b0, a, 8'h00, r);
    chk8(r, e);
  endtask : rd_chk
  task automatic do_init(input logic [7:0] c, input logic z);
    int j;
    ld_cnt = 0;
    @(posedge clk_sys);
    ld_ctrl <= c;
    ld_zero_lsb <= z;
    init_start <= 1'b1;
    @(posedge clk_sys);
    init_start <= 1'b0;
    j = 0;
    do @(posedge clk_sys); while (init_done !== 1'b1 && ++j < 4000);
    chk1(init_done, 1'b1);
    ctrl_m = c;
  endtask : do_init
  task automatic pix_run(input int n);
    pix_on = 1'b1;
    repeat (n) @(posedge clk_sys);
    pix_on = 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : pix_run
  always @(posedge clk_sys) begin
    if (ld_req === 1'b1) begin
      chk8({6'h00, ld_table}, 8'(ld_cnt / 256));
      chk8(ld_index, 8'(ld_cnt % 256));
      ld_cnt++;
    end
  end
  always @(posedge clk_sys) begin
    if (!rstn) begin
      pq.delete();
    end else begin
      if (pq.size() == 3) begin
        pe = pq.pop_front();
        chk1(out_valid, pe.v);
        if (pe.c && pe.v) begin
          chk8(out_r, pe.p[23:16]);
          chk8(out_g, pe.p[15:8]);
          chk8(out_b, pe.p[7:0]);
        end
      end
      r8 = pix_fix ? 8'h80 : 8'($random(seed));
      g8 = pix_fix ? 8'h80 : 8'($random(seed));
      b8 = pix_fix ? 8'h80 : 8'($random(seed));
      vb = pix_on && (pix_fix || 1'($random(seed)));
      pix_r <= r8;
      pix_g <= g8;
      pix_b <= b8;
      pix_valid <= vb;
      pq.push_back({pix_on, vb, exp_px(r8, 0), exp_px(g8, 1), exp_px(b8, 2)});
    end
  end
  initial begin
    #(8 * 60000);
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end
  initial begin
    seed = 32'h991c_a419;
    {n_fail, n_tests, ld_cnt} = '0;
    {rstn, init_start, ld_zero_lsb, cmd_valid, cmd_we, msk} = '0;
    {pix_valid, frame_start, pix_on, pix_fix} = '0;
    {ld_ctrl, cmd_addr, cmd_wdata, pix_r, pix_g, pix_b} = '0;
    ctrl_m = CTRL_RST;
    for (k = 0; k < 768; k++) src[k / 256][k % 256] = 8'($random(seed));
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    chk8({3'h0, pat_sel}, {3'h0, PAT_RST});
    rd_chk(ADR_CTRL, CTRL_RST);
    rd_chk(8'h20, 8'h00);
    rd_chk(ADR_LDAT, 8'h00);
    pix_run(100);
    do_init(8'h01, 1'b0);
    chk8(8'(ld_cnt / 4), 8'hc0);
    rd_chk(ADR_STAT, 8'h0f);
    pix_run(300);
    wr(ADR_PAGE, PAGE_GREEN);
    rd_chk(ADR_PAGE, PAGE_GREEN);
    wr(ADR_LIDX, 8'hfc);
    for (k = 0; k < 4; k++) rd_chk(ADR_LDAT, src[1][252 + k]);
    wr(ADR_PAGE, PAGE_RED);
    wr(ADR_LIDX, 8'h05);
    wr(ADR_LDAT, ~src[0][5]);
    wr(ADR_LIDX, 8'h05);
    rd_chk(ADR_LDAT, src[0][5]);
    wr(ADR_CTRL, 8'h03);
    rd_chk(ADR_CTRL, 8'h03);
    pix_fix = 1'b1;
    pix_on = 1'b1;
    wr(ADR_LIDX, 8'h00);
    for (k = 0; k < 6; k++) begin
      src[0][k] = 8'($random(seed));
      wr(ADR_LDAT, src[0][k]);
    end
    pix_run(10);
    pix_fix = 1'b0;
    wr(ADR_LIDX, 8'h00);
    for (k = 0; k < 6; k++) rd_chk(ADR_LDAT, src[0][k]);
    do_init(8'h0f, 1'b1);
    chk8(8'(ld_cnt / 4), 8'hc0);
    msk = 1'b1;
    pix_run(300);
    wr(ADR_PIADR, IND_FIXED);
    wr(ADR_PIDAT, 8'h05);
    repeat (2) @(posedge clk_sys);
    chk8({3'h0, pat_sel}, 8'h05);
    wr(ADR_PIADR, IND_SLOT_CNT);
    rd_chk(ADR_PIDAT, 8'h10);
    for (k = 0; k < 16; k++) begin
      wr(ADR_PIADR, 8'(k));
      wr(ADR_PIDAT, 8'(k % 6 + 1));
    end
    wr(ADR_PIADR, 8'h03);
    rd_chk(ADR_PIDAT, 8'h04);
    wr(ADR_CTRL, 8'h1f);
    for (k = 1; k < 20; k++) begin
      @(posedge clk_sys);
      frame_start <= 1'b1;
      @(posedge clk_sys);
      frame_start <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk8({3'h0, pat_sel}, 8'((k % 16) % 6 + 1));
    end
    report_and_stop();
  end
endmodule : pattern_scroll_white_balance_lut_tb
`default_nettype wire
